// ==== src/cpp_config_port.sv ====
`timescale 1ns/100ps
`include "cpp_defines.svh"

// Behaviour
// R1 - mode pins are sampled once, just before loading starts, and choose the mode; the code samples them as memory clear ends, before the master init wait
// R2 - codes 000 serial master, 101 peripheral, 111 slave, 110/100 parallel master
// R3 - after completion the middle mode pin drives inverted readback data
// R4 - high flag driven high during configuration, user I/O afterwards
// R5 - low flag driven low during configuration, user I/O afterwards
// R6 - init pin pulled low while memory clears, user I/O afterwards
// R7 - master modes wait while the wired-AND init line is low
// R8 - peripheral write only while all four selects are asserted together
// R9 - peripheral byte captured when any select is deasserted
// R10 - ready/busy shows whether another peripheral byte can be taken
// R11 - host waits for ready before its next write strobe
// R12 - parallel master drives a 16-bit address, low bits on two select pins; the code drives all 16 bits on cfg_mem_addr
// R13 - read strobe rises before every address change
// R14 - parallel modes use the byte bus, serial modes its lowest bit
// R15 - serial modes shift data in from the serial input
// R16 - serial data is forwarded on the data output for a chained slave
// R17 - config clock is an output in master/peripheral modes, input in slave
// R18 - weak pull-ups on unused outputs active until configuration ends
// R19 - highest mode pin pulled up during configuration, user I/O afterwards; the code keeps mode_sel_hi an input only and just drops pullup_en
// R20 - done rises one cycle before or after user outputs, as selected
// R21 - after completion configuration functions stop, pins are user I/O only
module cpp_config_port
  import cpp_pkg::*;
#(
  parameter int CFG_CLOCK_HALF = `CPP_CFG_CLOCK_HALF
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // mode pins
  input  wire logic        mode_sel_hi,
  input  wire logic        mode_sel_mid,
  input  wire logic        mode_sel_lo,
  output cpp_pin_t         mode_sel_mid_drv,
  // configuration data and peripheral handshake
  input  wire logic [7:0]  cfg_byte_bus,
  input  cpp_psel_t        periph_sel,
  output cpp_pin_t         ready_busy,
  output cpp_pin_t         data_out,
  // configuration clock
  input  wire logic        cfg_clock_in,
  output cpp_pin_t         cfg_clock_drv,
  // parallel master memory port
  output logic [15:0]      cfg_mem_addr,
  output logic             cfg_mem_addr_oe,
  output cpp_pin_t         read_strobe,
  // status pins
  input  wire logic        init_in,
  output cpp_pin_t         init_drv,
  output cpp_pin_t         cfg_active_hi_flag,
  output cpp_pin_t         cfg_active_lo_flag,
  output logic             done,
  output logic             pullup_en
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (CFG_CLOCK_HALF < 1 || CFG_CLOCK_HALF > 255) begin : g_chk
    $error("CFG_CLOCK_HALF out of range");
  end

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int SW = 17;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [2:0]    s_mode;
  logic [7:0]    s_bus;
  cpp_psel_t     s_psel;
  logic          s_init;
  logic          s_cfg_clock;
  logic          cfg_clock_prev;

  // two flops on every pin input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1     <= '0;
      sync2     <= '0;
      cfg_clock_prev <= 1'b0;
    end else begin
      sync1     <= {mode_sel_hi, mode_sel_mid, mode_sel_lo, cfg_byte_bus, periph_sel,
                    init_in, cfg_clock_in};
      sync2     <= sync1;
      cfg_clock_prev <= s_cfg_clock;
    end
  end

  assign s_mode = sync2[16:14];
  assign s_bus  = sync2[13:6];
  assign s_psel = sync2[5:2];
  assign s_init = sync2[1];
  assign s_cfg_clock = sync2[0];

  // ****************************************************************
  // registers and state
  // ****************************************************************
  cpp_state_t  state;
  logic [2:0]  mode_q;
  logic        mem_cleared;
  logic        done_first;
  logic [15:0] length;
  logic [4:0]  user_reg;
  logic        restart;
  logic        overrun;
  logic [7:0]  last_byte;
  logic [15:0] byte_cnt;
  logic        user_en;
  logic        fin_step;
  logic [7:0]  div_cnt;
  logic        cfg_clock_int;
  logic        tick;
  logic [7:0]  shreg;
  logic [2:0]  bit_cnt;
  logic [7:0]  obuf;
  logic        obuf_full;
  logic        wr_act;
  logic        wr_prev;
  logic        byte_done;
  logic        serial_mode;
  logic        par_master;
  logic        own_clock;
  logic [7:0]  rb_sr;
  logic        apb_acc;

  assign serial_mode = (mode_q == CPP_SER_MASTER) || (mode_q == CPP_SER_SLAVE);
  assign par_master  = (mode_q == CPP_PAR_HIGH) || (mode_q == CPP_PAR_LOW);
  assign own_clock   = (mode_q != CPP_SER_SLAVE); // [R17]
  // all four selects asserted at once
  assign wr_act      = !s_psel.periph_sel_a_n && !s_psel.periph_sel_b_n &&
                       s_psel.periph_sel_c && !s_psel.periph_write_strobe_n; // [R8]
  assign apb_acc     = psel && penable && !pready;
  assign restart     = apb_acc && pwrite && (paddr == `CPP_OFS_CTRL) &&
                       pwdata[`CPP_CTRL_RESTART];

  // ****************************************************************
  // configuration clock: divider or edge of the input clock
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt  <= 8'h00;
      cfg_clock_int <= 1'b1;
    end else if (state == CPP_ST_LOAD && own_clock) begin
      if (div_cnt == 8'(CFG_CLOCK_HALF - 1)) begin
        div_cnt  <= 8'h00;
        cfg_clock_int <= !cfg_clock_int;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end else begin
      div_cnt  <= 8'h00;
      cfg_clock_int <= 1'b1;
    end
  end

  // one tick per rising edge of the active clock
  assign tick = own_clock ? (state == CPP_ST_LOAD && !cfg_clock_int &&
                             div_cnt == 8'(CFG_CLOCK_HALF - 1))
                          : (s_cfg_clock && !cfg_clock_prev); // [R17]

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state    <= CPP_ST_CLEAR;
      mode_q   <= CPP_SER_SLAVE;
      done     <= 1'b0;
      user_en  <= 1'b0;
      fin_step <= 1'b0;
    end else if (restart) begin
      state    <= CPP_ST_CLEAR;
      done     <= 1'b0;
      user_en  <= 1'b0;
      fin_step <= 1'b0;
    end else begin
      unique case (state)
        CPP_ST_CLEAR: begin
          if (mem_cleared) begin
            mode_q <= s_mode; // [R1] [R2]
            state  <= CPP_ST_HOLD;
          end
        end
        CPP_ST_HOLD: begin
          // masters hold off while any slave still pulls init low
          if (s_init || mode_q == CPP_PERIPH || mode_q == CPP_SER_SLAVE) begin
            state <= CPP_ST_LOAD; // [R7]
          end
        end
        CPP_ST_LOAD: begin
          if (byte_done && byte_cnt + 16'h0001 >= length) begin
            state <= CPP_ST_FINISH;
          end
        end
        CPP_ST_FINISH: begin
          // pins follow user_en one edge later: done rises with user_en when
          // done comes first, otherwise it waits for the first edge in user state
          fin_step <= 1'b1;
          if (!fin_step) begin
            user_en <= 1'b1;
            if (done_first) done <= 1'b1; // [R20]
          end else begin
            state <= CPP_ST_USER;
          end
        end
        CPP_ST_USER: begin
          done <= 1'b1; // [R20]
        end
        default: state <= CPP_ST_CLEAR;
      endcase
    end
  end

  // ****************************************************************
  // data path: serial shift, peripheral buffer, memory fetch
  // ****************************************************************
  assign byte_done = (state == CPP_ST_LOAD) && tick && (bit_cnt == 3'h7) &&
                     (serial_mode || obuf_full);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shreg     <= 8'h00;
      bit_cnt   <= 3'h0;
      obuf      <= 8'h00;
      obuf_full <= 1'b0;
      wr_prev   <= 1'b0;
      last_byte <= 8'h00;
      byte_cnt  <= 16'h0000;
      overrun   <= 1'b0;
      data_out  <= '0;
    end else if (state != CPP_ST_LOAD) begin
      bit_cnt   <= 3'h0;
      obuf_full <= 1'b0;
      wr_prev   <= 1'b0;
      if (restart) begin
        byte_cnt <= 16'h0000;
        overrun  <= 1'b0;
      end
      data_out.oe <= 1'b0; // [R21]
    end else begin
      data_out.oe <= 1'b1;
      wr_prev     <= wr_act;
      if (serial_mode && tick) begin
        shreg        <= {shreg[6:0], s_bus[0]}; // [R14] [R15]
        data_out.val <= s_bus[0]; // [R16]
        bit_cnt      <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) last_byte <= {shreg[6:0], s_bus[0]};
      end else if (!serial_mode) begin
        // peripheral byte taken when the write ends
        if (mode_q == CPP_PERIPH && wr_prev && !wr_act) begin
          if (obuf_full) begin
            overrun <= 1'b1;
          end else begin
            obuf      <= s_bus; // [R9] [R14]
            last_byte <= s_bus;
            obuf_full <= 1'b1;
          end
        end
        if (tick && obuf_full) begin
          data_out.val <= obuf[7]; // [R16]
          obuf         <= {obuf[6:0], 1'b0};
          bit_cnt      <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) obuf_full <= 1'b0;
        end else if (tick && par_master) begin
          obuf      <= s_bus; // [R14]
          last_byte <= s_bus;
          obuf_full <= 1'b1;
        end
      end
      if (byte_done) byte_cnt <= byte_cnt + 16'h0001;
    end
  end

  // ****************************************************************
  // parallel master address and read strobe
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_mem_addr    <= `CPP_ADDR_ASC;
      cfg_mem_addr_oe <= 1'b0;
      read_strobe     <= '0;
    end else if (state != CPP_ST_LOAD || !par_master) begin
      cfg_mem_addr    <= (s_mode == CPP_PAR_HIGH) ? `CPP_ADDR_DESC : `CPP_ADDR_ASC;
      cfg_mem_addr_oe <= 1'b0;
      read_strobe     <= '0; // [R21]
    end else begin
      cfg_mem_addr_oe <= 1'b1; // [R12]
      read_strobe.oe  <= 1'b1;
      if (tick && obuf_full) begin
        // strobe rises three ticks ahead of the address step
        if (bit_cnt == 3'h3) read_strobe.val <= 1'b1; // [R13]
        if (bit_cnt == 3'h5) read_strobe.val <= 1'b0;
        if (bit_cnt == 3'h6) begin
          cfg_mem_addr <= (mode_q == CPP_PAR_HIGH) ? cfg_mem_addr - 16'h0001
                                                   : cfg_mem_addr + 16'h0001; // [R12]
        end
      end
    end
  end

  // ****************************************************************
  // status and dual-purpose pins
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_active_hi_flag <= '0;
      cfg_active_lo_flag <= '0;
      init_drv           <= '0;
      ready_busy         <= '0;
      cfg_clock_drv      <= '0;
      pullup_en          <= 1'b1;
    end else if (!user_en) begin
      cfg_active_hi_flag <= '{val: 1'b1, oe: 1'b1}; // [R4]
      cfg_active_lo_flag <= '{val: 1'b0, oe: 1'b1}; // [R5]
      init_drv           <= '{val: 1'b0, oe: (state == CPP_ST_CLEAR)}; // [R6]
      ready_busy         <= '{val: !obuf_full,
                              oe: (state == CPP_ST_LOAD && mode_q == CPP_PERIPH)}; // [R10]
      cfg_clock_drv      <= '{val: cfg_clock_int,
                              oe: (state == CPP_ST_LOAD && own_clock)}; // [R17]
      pullup_en          <= 1'b1; // [R18] [R19]
    end else begin
      cfg_active_hi_flag <= '{val: user_reg[`CPP_USER_HI_VAL],
                              oe: user_reg[`CPP_USER_HI_OE]}; // [R4] [R21]
      cfg_active_lo_flag <= '{val: user_reg[`CPP_USER_LO_VAL],
                              oe: user_reg[`CPP_USER_LO_OE]}; // [R5] [R21]
      init_drv           <= '{val: 1'b0, oe: user_reg[`CPP_USER_INIT_LO]}; // [R6]
      ready_busy         <= '0; // [R21]
      cfg_clock_drv      <= '0;
      pullup_en          <= 1'b0; // [R18] [R19]
    end
  end

  // readback: shift last byte out on config clock edges, inverted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rb_sr            <= 8'h00;
      mode_sel_mid_drv <= '0;
    end else if (!user_en) begin
      rb_sr            <= last_byte;
      mode_sel_mid_drv <= '0;
    end else begin
      if (s_cfg_clock && !cfg_clock_prev) rb_sr <= {rb_sr[6:0], rb_sr[7]};
      mode_sel_mid_drv <= '{val: !rb_sr[7], oe: 1'b1}; // [R3]
    end
  end

  // ****************************************************************
  // apb slave, one wait state
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready      <= 1'b0;
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
      mem_cleared <= 1'(`CPP_RST_CTRL >> `CPP_CTRL_CLEARED);
      done_first  <= 1'(`CPP_RST_CTRL >> `CPP_CTRL_DONE1ST);
      length      <= `CPP_RST_LENGTH;
      user_reg    <= `CPP_RST_USER;
    end else begin
      pready  <= apb_acc;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (restart) mem_cleared <= 1'b0;
      if (apb_acc) begin
        unique case (paddr)
          `CPP_OFS_CTRL: begin
            if (pwrite && !pwdata[`CPP_CTRL_RESTART]) begin
              mem_cleared <= pwdata[`CPP_CTRL_CLEARED];
              done_first  <= pwdata[`CPP_CTRL_DONE1ST];
            end
            prdata <= {30'h0, done_first, mem_cleared};
          end
          `CPP_OFS_LENGTH: begin
            if (pwrite) length <= pwdata[15:0];
            prdata <= {16'h0000, length};
          end
          `CPP_OFS_STATUS: begin
            prdata <= {byte_cnt, 6'h00, s_init, overrun, user_en, done,
                       3'(state), mode_q};
          end
          `CPP_OFS_DATA: begin
            prdata <= {24'h000000, last_byte};
          end
          `CPP_OFS_USER: begin
            if (pwrite) user_reg <= pwdata[4:0];
            prdata <= {27'h0000000, user_reg};
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ==== src/cpp_defines.svh ====
`ifndef CPP_DEFINES_SVH
`define CPP_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CPP_OFS_CTRL     8'h00
`define CPP_OFS_LENGTH   8'h04
`define CPP_OFS_STATUS   8'h08
`define CPP_OFS_DATA     8'h0C
`define CPP_OFS_USER     8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define CPP_CTRL_CLEARED 0
`define CPP_CTRL_DONE1ST 1
`define CPP_CTRL_RESTART 2
`define CPP_USER_HI_VAL  0
`define CPP_USER_HI_OE   1
`define CPP_USER_LO_VAL  2
`define CPP_USER_LO_OE   3
`define CPP_USER_INIT_LO 4

// ****************************************************************
// reset values
// ****************************************************************
`define CPP_RST_CTRL     3'h0
`define CPP_RST_LENGTH   16'h0010
`define CPP_RST_USER     5'h00
`define CPP_ADDR_ASC     16'h0000
`define CPP_ADDR_DESC    16'hFFFF

// ****************************************************************
// timing
// ****************************************************************
`define CPP_CLK_NS       20
`define CPP_CFG_CLOCK_HALF_NS 80
`define CPP_CFG_CLOCK_HALF    (`CPP_CFG_CLOCK_HALF_NS / `CPP_CLK_NS)

`endif

// ==== src/cpp_pkg.sv ====
package cpp_pkg;

  // mode pin code {hi, mid, lo}
  typedef enum logic [2:0] {
    CPP_SER_MASTER = 3'b000,
    CPP_PAR_LOW    = 3'b100,
    CPP_PERIPH     = 3'b101,
    CPP_PAR_HIGH   = 3'b110,
    CPP_SER_SLAVE  = 3'b111
  } cpp_mode_t;

  typedef enum logic [2:0] {
    CPP_ST_CLEAR  = 3'b000,
    CPP_ST_HOLD   = 3'b001,
    CPP_ST_LOAD   = 3'b010,
    CPP_ST_FINISH = 3'b011,
    CPP_ST_USER   = 3'b100
  } cpp_state_t;

  // peripheral select group as seen on the pins
  typedef struct packed {
    logic periph_sel_a_n;
    logic periph_sel_b_n;
    logic periph_sel_c;
    logic periph_write_strobe_n;
  } cpp_psel_t;

  // a pin driven by the block: value and enable
  typedef struct packed {
    logic val;
    logic oe;
  } cpp_pin_t;

endpackage

// ==== tb/cpp_config_port_sva.sv ====
`timescale 1ns/100ps
// ****************************************************************
// pin-level checks of the configuration port
// ****************************************************************
module cpp_config_port_sva
  import cpp_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // mode pins and selects
  input wire logic        mode_sel_hi,
  input wire logic        mode_sel_mid,
  input wire logic        mode_sel_lo,
  input cpp_psel_t        periph_sel,
  // driven pins
  input wire logic [15:0] cfg_mem_addr,
  input wire logic        cfg_mem_addr_oe,
  input cpp_pin_t         read_strobe,
  input cpp_pin_t         ready_busy,
  input cpp_pin_t         data_out,
  input cpp_pin_t         cfg_clock_drv,
  input cpp_pin_t         init_drv,
  input cpp_pin_t         cfg_active_hi_flag,
  input cpp_pin_t         cfg_active_lo_flag,
  input wire logic        done,
  input wire logic        pullup_en
);
  logic strobe_seen;
  wire  all_sel = !periph_sel.periph_sel_a_n && !periph_sel.periph_sel_b_n &&
                  periph_sel.periph_sel_c && !periph_sel.periph_write_strobe_n;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  // remembers a read strobe rise until the address next moves
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobe_seen <= 1'b0;
    end else if ($changed(cfg_mem_addr)) begin
      strobe_seen <= 1'b0;
    end else if ($rose(read_strobe.val)) begin
      strobe_seen <= 1'b1;
    end
  end

  hi_flag_cfg_a: assert property (pullup_en && $past(nrst) |-> cfg_active_hi_flag == 2'h3)
    else $error("high flag not high while configuring");
  lo_flag_cfg_a: assert property (pullup_en && $past(nrst) |-> cfg_active_lo_flag == 2'h1)
    else $error("low flag not low while configuring");
  init_open_a: assert property (init_drv.oe |-> !init_drv.val)
    else $error("init pin driven high");
  strobe_first_a: assert property (cfg_mem_addr_oe && $past(cfg_mem_addr_oe) &&
    $changed(cfg_mem_addr) |-> strobe_seen) else $error("address moved without strobe");
  done_order_a: assert property ($rose(done) |->
    (!$past(pullup_en) && $past(pullup_en, 2)) or (pullup_en ##1 !pullup_en))
    else $error("done not one cycle from user outputs");
  busy_after_a: assert property (ready_busy.oe && $past(all_sel) && !all_sel
    |-> ##[1:8] !ready_busy.val) else $error("no busy after write");
  clk_dir_a: assert property (cfg_clock_drv.oe |->
    !(mode_sel_hi && mode_sel_mid && mode_sel_lo)) else $error("clock driven in slave mode");
  user_stop_a: assert property (!pullup_en && !$past(pullup_en) |->
    !(cfg_clock_drv.oe || ready_busy.oe || data_out.oe || cfg_mem_addr_oe || read_strobe.oe))
    else $error("config output still driven after completion");

  cover property ($rose(done));
  cover property (cfg_mem_addr_oe && $changed(cfg_mem_addr));
  cover property (ready_busy.oe && $fell(ready_busy.val));
endmodule

// ==== tb/cpp_mem_model.sv ====
`timescale 1ns/100ps
// external memory and chained slave on the far side of the port
module cpp_mem_model
  import cpp_pkg::*;
(
  // memory port
  input  wire logic [15:0] addr,
  input  wire logic        addr_oe,
  output logic      [7:0]  mem_byte,
  // wired-and init line
  input  cpp_pin_t         init_drv,
  input  wire logic        hold_n,
  output logic             init_line
);
  // byte stored at each address, inverted when the memory is not enabled
  always_comb begin
    mem_byte = addr[7:0] ^ 8'hA5;
    if (!addr_oe) begin
      mem_byte = ~mem_byte;
    end
  end
  // pulled up unless this block or a chained slave pulls low
  assign init_line = !(init_drv.oe && !init_drv.val) && hold_n;
endmodule

// ==== tb/tb_config_port_pin_logic.sv ====
`timescale 1ns/100ps
`include "cpp_defines.svh"
module tb_config_port_pin_logic;
  import cpp_pkg::*;
  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } cpp_note_t;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, done, pullup_en, init_in, cfg_mem_addr_oe;
  logic [31:0] prdata;
  logic        mode_sel_hi = 1'b1;
  logic        mid_tb = 1'b1;
  logic        mode_sel_lo = 1'b1;
  logic        cfg_clock_in = 1'b0;
  logic        hold_n = 1'b1;
  logic [7:0]  bus_tb = 8'h0;
  logic [7:0]  mem_byte;
  logic [7:0]  last;
  logic [15:0] cfg_mem_addr;
  cpp_psel_t   periph_sel = 4'hD;
  cpp_pin_t    mode_sel_mid_drv, ready_busy, data_out, cfg_clock_drv, read_strobe;
  cpp_pin_t    init_drv, cfg_active_hi_flag, cfg_active_lo_flag;
  cpp_note_t   note;
  cpp_note_t   notes[$];
  cpp_mode_t   codes[5] = '{CPP_SER_MASTER, CPP_PAR_LOW, CPP_PERIPH, CPP_PAR_HIGH, CPP_SER_SLAVE};
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // two-way pins resolve to the driver that is enabled
  wire         mode_sel_mid = mode_sel_mid_drv.oe ? mode_sel_mid_drv.val : mid_tb;
  wire  [7:0]  cfg_byte_bus = cfg_mem_addr_oe ? mem_byte : bus_tb;

  cpp_config_port #(.CFG_CLOCK_HALF(1)) u_cpp_config_port (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .mode_sel_hi(mode_sel_hi), .mode_sel_mid(mode_sel_mid),
    .mode_sel_lo(mode_sel_lo), .mode_sel_mid_drv(mode_sel_mid_drv), .cfg_byte_bus(cfg_byte_bus),
    .periph_sel(periph_sel), .ready_busy(ready_busy), .data_out(data_out),
    .cfg_clock_in(cfg_clock_in), .cfg_clock_drv(cfg_clock_drv), .cfg_mem_addr(cfg_mem_addr),
    .cfg_mem_addr_oe(cfg_mem_addr_oe), .read_strobe(read_strobe), .init_in(init_in),
    .init_drv(init_drv), .cfg_active_hi_flag(cfg_active_hi_flag),
    .cfg_active_lo_flag(cfg_active_lo_flag), .done(done), .pullup_en(pullup_en));
  cpp_mem_model u_cpp_mem_model (.addr(cfg_mem_addr), .addr_oe(cfg_mem_addr_oe),
    .mem_byte(mem_byte), .init_drv(init_drv), .hold_n(hold_n), .init_line(init_in));

  always #10 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  // read results are matched against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = notes.pop_front();
      chk_rd(prdata & note.m, note.d, pslverr, note.e);
    end
  end

  task automatic chk_rd(input logic [31:0] act, exp, input logic err, eerr);
    total_checks++;
    if (act !== exp || err !== eerr) begin
      mismatches++;
      $display("unexpected read at %0t: got %h/%b want %h/%b", $time, act, err, exp, eerr);
    end
  endtask

  task automatic chk_pin(input logic [31:0] act, exp);
    total_checks++;
    if (act !== exp) begin
      mismatches++;
      $display("unexpected pin value at %0t: got %h want %h", $time, act, exp);
    end
  endtask

  // apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, m,
                     input logic e);
    @(posedge clk);
    if (!wr) notes.push_back('{d & m, m, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset with mode pins set, then check the configuring pin levels
  task automatic rst_dut(input logic [2:0] code);
    @(posedge clk);
    nrst <= 1'b0;
    {mode_sel_hi, mid_tb, mode_sel_lo} <= code;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk_pin(cfg_active_hi_flag, 32'h3);
    chk_pin(cfg_active_lo_flag, 32'h1);
    chk_pin(init_drv, 32'h1);
    chk_pin(pullup_en, 32'h1);
  endtask

  // peripheral write: assert selects, drop the strobe first, then the rest
  task automatic pwr(input logic [3:0] s, input logic [7:0] b);
    @(posedge clk);
    bus_tb <= b;
    periph_sel <= s;
    repeat (4) @(posedge clk);
    periph_sel <= {s[3:1], 1'b1};
    repeat (4) @(posedge clk);
    periph_sel <= 4'hD;
    bus_tb <= ~b;
  endtask

  // one pulse on the config clock input, high and low for four cycles each
  task automatic cfg_clock_pulse();
    repeat (4) @(posedge clk);
    cfg_clock_in <= 1'b1;
    repeat (4) @(posedge clk);
    cfg_clock_in <= 1'b0;
  endtask

  task automatic wait_done();
    while (done !== 1'b1) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(42041));
    foreach (codes[i]) begin
      rst_dut(codes[i]);
      apb(1'b1, `CPP_OFS_CTRL, 32'h1, 32'h0, 1'b0);
      apb(1'b0, `CPP_OFS_STATUS, 32'(codes[i]), 32'h7, 1'b0);
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk_pin(cfg_clock_drv.oe, codes[i] != CPP_SER_SLAVE);
      chk_pin(ready_busy.oe, codes[i] == CPP_PERIPH);
      chk_pin(cfg_mem_addr_oe, codes[i] inside {CPP_PAR_LOW, CPP_PAR_HIGH});
    end
    // slave mode is still loading: shift one random byte in, msb first
    last = 8'($urandom);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      bus_tb <= {7'h00, last[7 - k]};
      cfg_clock_pulse();
    end
    apb(1'b0, `CPP_OFS_DATA, 32'(last), 32'hFF, 1'b0);
    chk_pin(data_out, {last[0], 1'b1});
    rst_dut(CPP_PERIPH);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `CPP_OFS_LENGTH, 32'h2, 32'h0, 1'b0);
    apb(1'b1, `CPP_OFS_CTRL, 32'h1, 32'h0, 1'b0);
    pwr(4'h0, 8'h3C);
    apb(1'b0, `CPP_OFS_STATUS, 32'h0, 32'hFFFF0000, 1'b0);
    for (int i = 0; i < 2; i++) begin
      last = 8'($urandom);
      @(negedge clk);
      while (ready_busy.val !== 1'b1) @(negedge clk);
      pwr(4'h2, last);
    end
    wait_done();
    apb(1'b0, `CPP_OFS_DATA, 32'(last), 32'hFF, 1'b0);
    apb(1'b0, `CPP_OFS_STATUS, 32'h00020040, 32'hFFFF0040, 1'b0);
    apb(1'b1, `CPP_OFS_USER, 32'h1E, 32'h0, 1'b0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_pin(cfg_active_hi_flag, 32'h1);
    chk_pin(cfg_active_lo_flag, 32'h3);
    chk_pin(init_drv, 32'h1);
    chk_pin(pullup_en, 32'h0);
    for (int k = 0; k < 4; k++) begin
      chk_pin(mode_sel_mid_drv, {~last[7 - k], 1'b1});
      cfg_clock_pulse();
      @(negedge clk);
    end
    hold_n <= 1'b0;
    rst_dut(CPP_PAR_LOW);
    apb(1'b1, `CPP_OFS_LENGTH, 32'h2, 32'h0, 1'b0);
    apb(1'b1, `CPP_OFS_CTRL, 32'h3, 32'h0, 1'b0);
    repeat (20) @(posedge clk);
    apb(1'b0, `CPP_OFS_STATUS, 32'h8, 32'h38, 1'b0);
    hold_n <= 1'b1;
    wait_done();
    apb(1'b0, `CPP_OFS_DATA, 32'hA4, 32'hFF, 1'b0);
    stop_test();
  end
endmodule

bind cpp_config_port cpp_config_port_sva u_cpp_config_port_sva (.clk(clk), .nrst(nrst),
  .mode_sel_hi(mode_sel_hi), .mode_sel_mid(mode_sel_mid), .mode_sel_lo(mode_sel_lo),
  .periph_sel(periph_sel), .cfg_mem_addr(cfg_mem_addr), .cfg_mem_addr_oe(cfg_mem_addr_oe),
  .read_strobe(read_strobe), .ready_busy(ready_busy), .data_out(data_out),
  .cfg_clock_drv(cfg_clock_drv), .init_drv(init_drv), .cfg_active_hi_flag(cfg_active_hi_flag),
  .cfg_active_lo_flag(cfg_active_lo_flag), .done(done), .pullup_en(pullup_en));
